/* File: verilog/stepper_regs_pkg.sv */
// Purpose: Constants for the stepper control register bank
// Assumes: Byte-wide registers at their byte offsets
// Notes:   Imported by the bank only; its helper cells do not use it
`default_nettype none

package stepper_regs_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_DIAG   = 8'h02;
  localparam logic [7:0] ADDR_DECAY  = 8'h04;
  localparam logic [7:0] ADDR_STEP   = 8'h05;
  localparam logic [7:0] ADDR_FAULT  = 8'h06;
  localparam logic [7:0] ADDR_STALL  = 8'h07;

  // Output and decay register fields
  localparam int EN_OUT_BIT = 7;
  localparam int TOFF_LSB   = 3;
  localparam int DECAY_LSB  = 0;

  // Step control fields
  localparam int DIR_BIT     = 7;
  localparam int STEP_BIT    = 6;
  localparam int DIR_SRC_BIT = 5;
  localparam int STP_SRC_BIT = 4;
  localparam int RES_LSB     = 0;

  // Fault configuration fields
  localparam int CLEAR_BIT = 7;
  localparam int LOCK_LSB  = 4;
  localparam int OL_EN_BIT = 3;
  localparam int OCP_BIT   = 2;
  localparam int OTS_BIT   = 1;
  localparam int WARN_BIT  = 0;

  // Stall configuration fields
  localparam int LEARN_BIT = 5;
  localparam int SDEN_BIT  = 4;
  localparam int SREP_BIT  = 3;

  // Diagnostic status fields
  localparam int ST_OTW   = 6;
  localparam int ST_OTS   = 5;
  localparam int ST_LRNOK = 4;
  localparam int ST_STALL = 3;
  localparam int ST_OCP   = 2;
  localparam int ST_OL    = 0;

  // Values after reset
  localparam logic [7:0] RST_DECAY = 8'h0F;
  localparam logic [7:0] RST_STEP  = 8'h06;
  localparam logic [7:0] RST_FAULT = 8'h30;
  localparam logic [7:0] RST_STALL = 8'h08;

  // Lock field codes
  localparam logic [2:0] LOCK_ON  = 3'h6;
  localparam logic [2:0] LOCK_OFF = 3'h3;

  // Decay styles
  typedef enum logic [2:0] {
    DEC_SLOW_SLOW = 3'h0,
    DEC_SLOW_M30  = 3'h1,
    DEC_SLOW_M60  = 3'h2,
    DEC_SLOW_FAST = 3'h3,
    DEC_M30_M30   = 3'h4,
    DEC_M60_M60   = 3'h5,
    DEC_DYNAMIC   = 3'h6,
    DEC_RIPPLE    = 3'h7
  } decay_t;

  // Step resolutions
  typedef enum logic [3:0] {
    RES_FULL100 = 4'h0,
    RES_FULL71  = 4'h1,
    RES_HALF_NC = 4'h2,
    RES_HALF    = 4'h3,
    RES_4       = 4'h4,
    RES_8       = 4'h5,
    RES_16      = 4'h6,
    RES_32      = 4'h7,
    RES_64      = 4'h8,
    RES_128     = 4'h9,
    RES_256     = 4'hA
  } res_t;

endpackage : stepper_regs_pkg

`default_nettype wire

/* File: verilog/strobe_bit.sv */
// Purpose: Self-clearing command bit
// Assumes: Set and done are synchronous one-cycle terms
// Notes:   HOLD=0 gives a one-cycle pulse; HOLD=1 waits for done
`default_nettype none

module strobe_bit #(
  parameter bit HOLD = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Command
  input  wire logic set,
  input  wire logic done,
  output logic      flag
);

  // Set wins over done so a fresh command is never lost
  always_ff @(posedge clk) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (HOLD) begin
      flag <= flag & ~done;
    end else begin
      flag <= 1'b0;
    end
  end

endmodule : strobe_bit

`default_nettype wire

/* File: verilog/fault_cell.sv */
// Purpose: Fault flag that latches or follows its condition
// Assumes: Condition inputs are synchronous levels
// Notes:   Latched flags need a clear pulse to drop
`default_nettype none

module fault_cell #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Condition and mode
  input  wire logic [W-1:0] cond,
  input  wire logic         retry,
  input  wire logic         clear,
  output logic      [W-1:0] flag
);

  // Retry mode tracks the condition; latched mode holds
  // until cleared, and a condition present at the clear wins
  always_ff @(posedge clk) begin
    if (rst) begin
      flag <= '0;
    end else if (retry) begin
      flag <= cond;
    end else begin
      flag <= cond | (flag & ~{W{clear}});
    end
  end

endmodule : fault_cell

`default_nettype wire

/* File: verilog/stepper_control_register_bank.sv */
// Purpose: Control register bank of the stepper driver
// Assumes: Register port and pins synchronous to REF_CLK
// Notes:   Read data appears one cycle after REG_RD
`default_nettype none

module stepper_control_register_bank
  import stepper_regs_pkg::*;
(
  // Clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       SRST,
  // Register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  output logic            REG_RVALID,
  // Step and direction pins
  input  wire logic       STEP_PIN,
  input  wire logic       DIR_PIN,
  // Indexer and chopper controls
  output logic            STEP_PULSE,
  output logic            STEP_DIR,
  output logic      [3:0] STEP_RES,
  output logic      [2:0] DECAY_MODE,
  output logic      [1:0] OFF_TIME,
  output logic            OUTPUT_EN,
  // Fault and stall conditions
  input  wire logic       OCP_EVENT,
  input  wire logic       OTS_EVENT,
  input  wire logic       OTW_EVENT,
  input  wire logic [1:0] OL_EVENT,
  input  wire logic       STALL_EVENT,
  input  wire logic       LEARN_DONE,
  // Fault and stall controls
  output logic            OPEN_LOAD_EN,
  output logic            STALL_DETECT_EN,
  output logic            STALL_LEARN,
  output logic            DRIVER_SHUTDOWN,
  output logic            FAULT_OUTPUT_N
);

  // Stored registers
  logic [7:0] decay_reg;
  logic [7:0] step_reg;
  logic [6:0] fault_reg;
  logic [7:0] stall_reg;

  // Strobes and flags
  logic       step_strobe;
  logic       clear_pulse;
  logic       learning;
  logic       learn_ok_reg;
  logic       ocp_flag;
  logic       ots_flag;
  logic [1:0] ol_flag;
  logic       stall_flag;
  logic       otw_reg;
  logic       pin_step_reg;

  // Decoded writes, fault summary and read data
  logic       locked;
  logic       wr_open;
  logic       wr_decay;
  logic       wr_step;
  logic       wr_fault;
  logic       wr_stall;
  logic       step_req;
  logic       clear_req;
  logic       learn_req;
  logic [2:0] wr_lock;
  logic       any_fault;
  logic [7:0] rdata_next;

  // Lock state is the stored lock code itself
  assign locked   = fault_reg[LOCK_LSB+:3] == LOCK_ON;
  assign wr_open  = REG_WR & ~locked;
  assign wr_decay = wr_open & (REG_ADDR == ADDR_DECAY);
  assign wr_step  = wr_open & (REG_ADDR == ADDR_STEP);
  assign wr_stall = wr_open & (REG_ADDR == ADDR_STALL);
  assign wr_fault = REG_WR & (REG_ADDR == ADDR_FAULT);
  assign wr_lock  = REG_WDATA[LOCK_LSB+:3];

  // Command bits taken from the written byte
  assign step_req  = wr_step & REG_WDATA[STEP_BIT];
  assign clear_req = wr_fault & REG_WDATA[CLEAR_BIT];
  assign learn_req = wr_stall & REG_WDATA[LEARN_BIT];

  // Decay and off-time register
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      decay_reg <= RST_DECAY;
    end else if (wr_decay) begin
      decay_reg <= REG_WDATA;
    end
  end

  // Step control; the step bit is never stored
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      step_reg <= RST_STEP;
    end else if (wr_step) begin
      step_reg <= REG_WDATA & ~(8'h01 << STEP_BIT);
    end
  end

  // Fault config: lock code opens or closes the bank
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      fault_reg <= RST_FAULT[6:0];
    end else if (wr_fault) begin
      if (locked) begin
        if (wr_lock == LOCK_OFF) begin
          fault_reg[LOCK_LSB+:3] <= LOCK_OFF;
        end
      end else begin
        fault_reg[3:0] <= REG_WDATA[3:0];
        if (wr_lock == LOCK_ON) begin
          fault_reg[LOCK_LSB+:3] <= LOCK_ON;
        end
      end
    end
  end

  // Stall config; reserved bits kept as written
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      stall_reg <= RST_STALL;
    end else if (wr_stall) begin
      stall_reg <= REG_WDATA & ~(8'h01 << LEARN_BIT);
    end
  end

  // One-cycle register step request
  strobe_bit #(
    .HOLD (1'b0)
  ) u_step (
    .clk  (REF_CLK),
    .rst  (SRST),
    .set  (step_req),
    .done (1'b0),
    .flag (step_strobe)
  );

  // One-cycle fault clear, honoured even when locked
  strobe_bit #(
    .HOLD (1'b0)
  ) u_clear (
    .clk  (REF_CLK),
    .rst  (SRST),
    .set  (clear_req),
    .done (1'b0),
    .flag (clear_pulse)
  );

  // Learn bit holds until the learning logic finishes
  strobe_bit #(
    .HOLD (1'b1)
  ) u_learn (
    .clk  (REF_CLK),
    .rst  (SRST),
    .set  (learn_req),
    .done (LEARN_DONE),
    .flag (learning)
  );

  // Learn success flag, dropped by a new learn or a clear
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      learn_ok_reg <= 1'b0;
    end else if (learning & LEARN_DONE) begin
      learn_ok_reg <= 1'b1;
    end else if (learn_req | clear_pulse) begin
      learn_ok_reg <= 1'b0;
    end
  end

  // Step pin edge history
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pin_step_reg <= 1'b0;
    end else begin
      pin_step_reg <= STEP_PIN;
    end
  end

  // Step source mux; pin edges are ignored in register mode
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      STEP_PULSE <= 1'b0;
    end else if (step_reg[STP_SRC_BIT]) begin
      STEP_PULSE <= step_strobe;
    end else begin
      STEP_PULSE <= STEP_PIN & ~pin_step_reg;
    end
  end

  // Direction source mux
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      STEP_DIR <= 1'b0;
    end else if (step_reg[DIR_SRC_BIT]) begin
      STEP_DIR <= step_reg[DIR_BIT];
    end else begin
      STEP_DIR <= DIR_PIN;
    end
  end

  // Overcurrent: latched or retrying
  fault_cell #(
    .W (1)
  ) u_ocp (
    .clk   (REF_CLK),
    .rst   (SRST),
    .cond  (OCP_EVENT),
    .retry (fault_reg[OCP_BIT]),
    .clear (clear_pulse),
    .flag  (ocp_flag)
  );

  // Overheat: latched or self-recovering
  fault_cell #(
    .W (1)
  ) u_ots (
    .clk   (REF_CLK),
    .rst   (SRST),
    .cond  (OTS_EVENT),
    .retry (fault_reg[OTS_BIT]),
    .clear (clear_pulse),
    .flag  (ots_flag)
  );

  // Open load per bridge, seen only while enabled
  fault_cell #(
    .W (2)
  ) u_ol (
    .clk   (REF_CLK),
    .rst   (SRST),
    .cond  (OL_EVENT & {2{fault_reg[OL_EN_BIT]}}),
    .retry (1'b0),
    .clear (clear_pulse),
    .flag  (ol_flag)
  );

  // Stall status, seen only while detection is on
  fault_cell #(
    .W (1)
  ) u_stall (
    .clk   (REF_CLK),
    .rst   (SRST),
    .cond  (STALL_EVENT & stall_reg[SDEN_BIT]),
    .retry (1'b0),
    .clear (clear_pulse),
    .flag  (stall_flag)
  );

  // Warning follows its condition; it is not a fault
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      otw_reg <= 1'b0;
    end else begin
      otw_reg <= OTW_EVENT;
    end
  end

  // Fault output summary
  assign any_fault = ocp_flag | ots_flag | (|ol_flag)
                   | (otw_reg & fault_reg[WARN_BIT])
                   | (stall_flag & stall_reg[SREP_BIT]);

  // Registered so the pin never glitches on mixed faults
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      FAULT_OUTPUT_N  <= 1'b1;
      DRIVER_SHUTDOWN <= 1'b0;
    end else begin
      FAULT_OUTPUT_N  <= ~any_fault;
      DRIVER_SHUTDOWN <= ocp_flag | ots_flag;
    end
  end

  // Configuration outputs straight from the flops
  assign DECAY_MODE      = decay_reg[DECAY_LSB+:3];
  assign OFF_TIME        = decay_reg[TOFF_LSB+:2];
  assign OUTPUT_EN       = decay_reg[EN_OUT_BIT];
  assign STEP_RES        = step_reg[RES_LSB+:4];
  assign OPEN_LOAD_EN    = fault_reg[OL_EN_BIT];
  assign STALL_DETECT_EN = stall_reg[SDEN_BIT];
  assign STALL_LEARN     = learning;

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = 8'h00;
    unique case (REG_ADDR)
      ADDR_DIAG: begin
        rdata_next[ST_OTW]   = otw_reg;
        rdata_next[ST_OTS]   = ots_flag;
        rdata_next[ST_LRNOK] = learn_ok_reg;
        rdata_next[ST_STALL] = stall_flag;
        rdata_next[ST_OCP]   = ocp_flag;
        rdata_next[ST_OL+:2] = ol_flag;
      end
      ADDR_DECAY: rdata_next = decay_reg;
      ADDR_STEP:  rdata_next = step_reg;
      ADDR_FAULT: rdata_next = {1'b0, fault_reg};
      ADDR_STALL: begin
        rdata_next            = stall_reg;
        rdata_next[LEARN_BIT] = learning;
      end
      default:    rdata_next = 8'h00;
    endcase
  end

  // Read data held until the next read; locking never blocks
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rdata_next;
      end
    end
  end

  // Checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SRST);

  // A step write right behind may move the source back to the pin
  sequence s_reg_step;
    step_req && REG_WDATA[STP_SRC_BIT] ##1 !wr_step;
  endsequence

  property p_reg_step;
    s_reg_step |-> step_strobe ##1 STEP_PULSE ##1 !STEP_PULSE;
  endproperty
  a_reg_step: assert property (p_reg_step)
    else $error("register step did not give one pulse");

  property p_step_reads_zero;
    REG_RD && REG_ADDR == ADDR_STEP |=> !REG_RDATA[STEP_BIT];
  endproperty
  a_step_reads_zero: assert property (p_step_reads_zero)
    else $error("step bit read back as one");

  property p_dir_pin;
    !step_reg[DIR_SRC_BIT] |=> STEP_DIR == $past(DIR_PIN);
  endproperty
  a_dir_pin: assert property (p_dir_pin)
    else $error("direction did not follow pin");

  property p_pin_step;
    !step_reg[STP_SRC_BIT] && STEP_PIN && !pin_step_reg
      |=> STEP_PULSE;
  endproperty
  a_pin_step: assert property (p_pin_step)
    else $error("pin step edge lost");

  property p_lock_holds;
    locked && REG_WR && REG_ADDR == ADDR_DECAY
      |=> $stable(decay_reg);
  endproperty
  a_lock_holds: assert property (p_lock_holds)
    else $error("write changed locked register");

  property p_unlock;
    locked && wr_fault && wr_lock == LOCK_OFF |=> !locked;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock code did not unlock");

  sequence s_clear_done;
    clear_pulse ##1 !clear_pulse;
  endsequence

  // A condition present with the clear pulse wins, so it is excluded
  property p_clear;
    clear_req ##1 (!OCP_EVENT && !clear_req)
      |-> s_clear_done and ##1 !ocp_flag;
  endproperty
  a_clear: assert property (p_clear)
    else $error("fault clear did not act");

  property p_ol_off;
    !fault_reg[OL_EN_BIT] && ol_flag == 2'h0 |=> ol_flag == 2'h0;
  endproperty
  a_ol_off: assert property (p_ol_off)
    else $error("open load flagged while disabled");

  property p_warn_hidden;
    !fault_reg[WARN_BIT] && !ocp_flag && !ots_flag
      && ol_flag == 2'h0 && !(stall_flag && stall_reg[SREP_BIT])
      |=> FAULT_OUTPUT_N;
  endproperty
  a_warn_hidden: assert property (p_warn_hidden)
    else $error("unreported warning drove fault output");

  property p_learn_end;
    learning && LEARN_DONE && !learn_req |=> !learning && learn_ok_reg;
  endproperty
  a_learn_end: assert property (p_learn_end)
    else $error("learn bit did not clear when done");

  property p_stall_set;
    STALL_EVENT && stall_reg[SDEN_BIT] |=> stall_flag;
  endproperty
  a_stall_set: assert property (p_stall_set)
    else $error("stall not flagged");

endmodule : stepper_control_register_bank

`default_nettype wire

/* File: sim/stepper_host_model.sv */
// Purpose: Host side model driving the register port and step pins
// Assumes: Requests change 1 ns after a rising clock edge
// Notes:   Released lines show the inverse of their last value
`default_nettype none

module stepper_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  // Step and direction pins
  output logic            step_pin,
  output logic            dir_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle levels from time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    {reg_wr, reg_rd, step_pin, dir_pin} = 4'h0;
  end

  // Single byte write; illegal host values are never sent
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 8'h07) v = v & 8'h38;
    if (a == 8'h05 && v[3:0] > 4'hA) v[3:0] = 4'hA;
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_wdata = v;
    reg_wr    = 1'b1;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~v;
  endtask : wr

  // Single byte read; data taken in the valid cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk);
    #1;
    // Valid stands for one cycle only, so take it right after the read edge
    v        = reg_rvalid;
    d        = reg_rdata;
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask : rd

  // One pin step with a low sample after it
  task automatic pin_step(input logic d);
    @(posedge clk);
    #1;
    dir_pin  = d;
    step_pin = 1'b1;
    @(posedge clk);
    #1;
    step_pin = 1'b0;
  endtask : pin_step

endmodule : stepper_host_model

`default_nettype wire

/* File: sim/stepper_control_register_bank_bench.sv */
// Purpose: Self-checking bench for the stepper control register bank
// Assumes: Host model drives the register port 1 ns after each edge
// Notes:   Integer model of registers, lock and step count compared
`default_nettype none

module stepper_control_register_bank_bench;
  timeunit 1ns;
  timeprecision 100ps;

  // Design connections
  logic        clk, srst, reg_wr, reg_rd, reg_rvalid, step_pin, dir_pin;
  logic        step_pulse, step_dir, output_en, ocp_event, ots_event;
  logic        otw_event, stall_event, learn_done, open_load_en;
  logic        stall_detect_en, stall_learn, driver_shutdown;
  logic        fault_output_n;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [3:0]  step_res;
  logic [2:0]  decay_mode;
  logic [1:0]  off_time, ol_event;
  // Reference model and bookkeeping
  int          m [8];
  bit          lk, lrn;
  int          ep, np, cyc, seed, mismatches, checked;
  logic [31:0] r;

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Step counting and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (step_pulse === 1'b1) np <= np + 1;
    if (cyc == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  stepper_control_register_bank u_stepper_control_register_bank (
    .REF_CLK(clk), .SRST(srst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .REG_RVALID(reg_rvalid), .STEP_PIN(step_pin), .DIR_PIN(dir_pin),
    .STEP_PULSE(step_pulse), .STEP_DIR(step_dir), .STEP_RES(step_res),
    .DECAY_MODE(decay_mode), .OFF_TIME(off_time), .OUTPUT_EN(output_en),
    .OCP_EVENT(ocp_event), .OTS_EVENT(ots_event), .OTW_EVENT(otw_event),
    .OL_EVENT(ol_event), .STALL_EVENT(stall_event),
    .LEARN_DONE(learn_done), .OPEN_LOAD_EN(open_load_en),
    .STALL_DETECT_EN(stall_detect_en), .STALL_LEARN(stall_learn),
    .DRIVER_SHUTDOWN(driver_shutdown), .FAULT_OUTPUT_N(fault_output_n));

  stepper_host_model u_stepper_host_model (
    .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .step_pin(step_pin), .dir_pin(dir_pin));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic fin(input string n);
    $display("finished %s", n);
  endtask : fin

  // Output level compare
  task automatic chk(input string n, input int e, input logic [7:0] g);
    checked++;
    if (g !== 8'(e)) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, 8'(e), g);
    end
  endtask : chk

  // Register read compare, valid strobe included
  task automatic rdc(input int a, input int e);
    logic [7:0] d;
    logic       v;
    u_stepper_host_model.rd(8'(a), d, v);
    checked++;
    if (v !== 1'b1 || d !== 8'(e)) begin
      mismatches++;
      $display("unexpected read %h: expected %h, seen %h", a, 8'(e), d);
    end
  endtask : rdc

  // Expected read value of a control register
  function automatic int mread(input int a);
    case (a)
      4: return m[4];
      5: return m[5] & 8'hBF;
      6: return (lk ? 8'h60 : 8'h30) | (m[6] & 8'h0F);
      7: return (m[7] & 8'hDF) | (lrn << 5);
      default: return 0;
    endcase
  endfunction : mread

  // Model update, then the real write
  task automatic mwr(input int a, input int d);
    if (a == 6 && lk) begin
      if (((d >> 4) & 7) == 3) lk = 1'b0;
    end else if (a == 6) begin
      m[6] = d & 15;
      if (((d >> 4) & 7) == 6) lk = 1'b1;
    end else if (!lk && a > 3 && a < 8) begin
      m[a] = d;
      if (a == 5 && (d & 8'h50) == 8'h50) ep++;
      if (a == 7 && (d & 8'h20) != 0) lrn = 1'b1;
    end
    u_stepper_host_model.wr(8'(a), 8'(d));
  endtask : mwr

  // Fault in latched or retry mode, then a clear
  task automatic fault_case(input int b, input int rt);
    mwr(6, 8'h30 | (rt << b));
    tick(1);
    if (b == 2) ocp_event = 1'b1;
    else ots_event = 1'b1;
    tick(3);
    chk("shutdown", 1, {7'h0, driver_shutdown});
    {ocp_event, ots_event} = 2'h0;
    tick(3);
    chk("shutdown", !rt, {7'h0, driver_shutdown});
    chk("fault_n", rt, {7'h0, fault_output_n});
    rdc(2, rt ? 0 : (b == 2 ? 8'h04 : 8'h20));
    mwr(6, 8'h80 | mread(6));
    tick(3);
    chk("fault_n", 1, {7'h0, fault_output_n});
    rdc(6, mread(6));
  endtask : fault_case

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    seed = 41;
    m = '{0, 0, 0, 0, 8'h0F, 8'h06, 8'h00, 8'h08};
    srst = 1'b1;
    {ocp_event, ots_event, otw_event, stall_event, learn_done} = 5'h00;
    ol_event = 2'h0;
    repeat (5) @(posedge clk);
    #1;
    srst = 1'b0;
    for (int a = 0; a < 8; a++) rdc(a, mread(a));
    chk("cfg", 8'h6F, {step_res, decay_mode, fault_output_n});
    chk("en", 0, {6'h0, open_load_en, stall_detect_en});
    mwr(3, 8'hFF);
    rdc(3, 0);
    fin("reset");
    for (int c = 0; c < 8; c++) begin
      r = $random(seed);
      mwr(4, {r[7:3], 3'(c)});
      tick(1);
      chk("decay", {r[7], r[4:3], 2'h0, 3'(c)},
          {output_en, off_time, 2'h0, decay_mode});
      rdc(4, mread(4));
    end
    for (int c = 0; c < 11; c++) begin
      mwr(5, c);
      tick(1);
      chk("res", c, {4'h0, step_res});
    end
    fin("codes");
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      mwr(5, {r[0], 1'(i >> 2), 2'(i), 4'h6});
      u_stepper_host_model.pin_step(r[1]);
      if ((m[5] & 8'h10) == 0) ep++;
      tick(3);
      chk("dir", (m[5] & 8'h20) ? (m[5] >> 7) & 1 : r[1],
          {7'h0, step_dir});
      chk("steps", ep, 8'(np));
      rdc(5, mread(5));
    end
    fin("step");
    for (int i = 0; i < 4; i++) fault_case(1 + (i >> 1), i & 1);
    for (int w = 0; w < 2; w++) begin
      mwr(6, 8'h30 | w);
      tick(1);
      otw_event = 1'b1;
      tick(3);
      chk("fault_n", !w, {7'h0, fault_output_n});
      rdc(2, 8'h40);
      otw_event = 1'b0;
      tick(3);
    end
    for (int e = 0; e < 2; e++) begin
      mwr(6, 8'h30 | (e << 3));
      tick(1);
      ol_event = 2'h3;
      tick(1);
      ol_event = 2'h0;
      tick(3);
      chk("ol_en", e, {7'h0, open_load_en});
      rdc(2, e * 3);
      mwr(6, 8'h80 | mread(6));
      tick(2);
    end
    fin("faults");
    for (int i = 0; i < 4; i++) begin
      mwr(7, ((i & 1) << 4) | ((i >> 1) << 3));
      tick(1);
      stall_event = 1'b1;
      tick(1);
      stall_event = 1'b0;
      tick(3);
      chk("stall_en", i & 1, {7'h0, stall_detect_en});
      chk("fault_n", i != 3, {7'h0, fault_output_n});
      rdc(2, (i & 1) << 3);
      mwr(6, 8'h80 | mread(6));
      tick(3);
    end
    mwr(7, 8'h28);
    tick(1);
    chk("learn", 1, {7'h0, stall_learn});
    rdc(7, mread(7));
    learn_done = 1'b1;
    tick(1);
    learn_done = 1'b0;
    lrn = 1'b0;
    tick(2);
    chk("learn", 0, {7'h0, stall_learn});
    rdc(7, mread(7));
    rdc(2, 8'h10);
    fin("stall");
    mwr(6, 8'h60);
    mwr(5, 8'h0A);
    mwr(7, 8'h10);
    mwr(4, 8'hF0);
    mwr(6, 8'h5F);
    ocp_event = 1'b1;
    tick(1);
    ocp_event = 1'b0;
    tick(3);
    chk("fault_n", 0, {7'h0, fault_output_n});
    mwr(6, 8'hE0);
    tick(3);
    chk("fault_n", 1, {7'h0, fault_output_n});
    for (int a = 4; a < 8; a++) rdc(a, mread(a));
    chk("res", mread(5) & 15, {4'h0, step_res});
    mwr(6, 8'h30);
    mwr(5, 8'h0A);
    mwr(6, 8'h50);
    mwr(5, 8'h08);
    for (int a = 4; a < 8; a++) rdc(a, mread(a));
    fin("lock");
    end_of_test();
  end

endmodule : stepper_control_register_bank_bench

`default_nettype wire
